// *** src/pwm_edge_map.vh ***
/*
 * Constants of the multi-mode PWM edge engine: widths, mode codes
 * and reset values.
 * Assumes it is included by bare name from the design files.
 */
`ifndef PWM_EDGE_MAP_VH
`define PWM_EDGE_MAP_VH

////////////////////////////////////////////////////////////////////////
// Widths
`define CNT_W         14
`define EVT_W         18
`define EVT_CNT_MSB   17
`define EVT_CNT_LSB   4
`define ADJ_W         16
`define VOLT_W        12
`define MODE_W        3

////////////////////////////////////////////////////////////////////////
// Mode select codes
`define MODE_NORMAL   3'h0
`define MODE_MULTI    3'h1
`define MODE_RESONANT 3'h2
`define MODE_TRIANG   3'h3
`define MODE_LEADING  3'h4

////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_CNT       14'h0000
`define RST_MODE      3'h0
`define RST_BYTE      8'h00

`endif

// *** src/sync_rect_unit.v ***
/*
 * Sync-rectifier on-time: ideal-diode calculation from firmware Vin/Vout
 * and the filter duty, plus a soft ramp that holds the drive off until
 * the output is nominal.
 * Assumes all inputs are on the same clock as this module.
 */
`timescale 1ns/1ps
`include "pwm_edge_map.vh"

module sync_rect_unit (
	// Clock and reset
	input  wire                 clock,
	input  wire                 reset,
	// Timing and control
	input  wire                 period_start,
	input  wire                 nominal_reached,
	input  wire                 ramp_enable,
	input  wire [7:0]           ramp_step,
	input  wire [7:0]           ramp_periods,
	// Calculation inputs
	input  wire [`VOLT_W-1:0]   vin,
	input  wire [`VOLT_W-1:0]   vout,
	input  wire [`CNT_W-1:0]    duty,
	// Results
	output reg  [`CNT_W-1:0]    on_time_q,
	output reg                  ramp_done_q
);

	reg  [`CNT_W-1:0]           ideal_q;
	reg  [7:0]                  div_q;
	reg  [25:0]                 quot;
	reg  [`CNT_W-1:0]           ideal_d;
	wire [`CNT_W:0]             step_sum;

	// Ideal on-time D*(Vin-Vout)/Vout, saturated to the counter width
	always @* begin
		quot = 26'h0000000;
		ideal_d = `RST_CNT;
		if (vout != 12'h000 && vin > vout) begin
			quot = ({12'h000, duty} * {14'h0000, vin - vout}) / {14'h0000, vout};
			ideal_d = (|quot[25:14]) ? 14'h3FFF : quot[13:0];
		end
	end

	assign step_sum = {1'b0, on_time_q} + {7'h00, ramp_step};

	// Ramp steps once per ramp_periods+1 boundaries; slow by design
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			ideal_q     <= `RST_CNT;
			on_time_q   <= `RST_CNT;
			div_q       <= `RST_BYTE;
			ramp_done_q <= 1'b0;
		end else if (period_start) begin
			ideal_q <= ideal_d;
			if (!nominal_reached) begin
				on_time_q   <= `RST_CNT;
				div_q       <= `RST_BYTE;
				ramp_done_q <= 1'b0;
			end else if (!ramp_enable || on_time_q >= ideal_q) begin
				on_time_q   <= ideal_q;
				ramp_done_q <= 1'b1;
			end else if (div_q >= ramp_periods) begin
				div_q     <= `RST_BYTE;
				on_time_q <= (step_sum > {1'b0, ideal_q}) ? ideal_q : step_sum[13:0];
			end else begin
				div_q <= div_q + 8'h01;
			end
		end
	end

endmodule // sync_rect_unit

// *** src/multi_mode_pwm_edge_engine.v ***
/*
 * Two-output PWM edge engine: period counter, mode equations for edge
 * targets, compare-driven outputs, triggers, blanking and sync-rectifier
 * on-time.
 * Assumes filter outputs and firmware settings are synchronous to clock.
 */
`timescale 1ns/1ps
`include "pwm_edge_map.vh"

module multi_mode_pwm_edge_engine (
	// Clock and reset
	input  wire                 clock,
	input  wire                 reset,
	// Timing settings
	input  wire [`CNT_W-1:0]    period_limit,
	input  wire [`CNT_W-1:0]    event1,
	input  wire [`EVT_W-1:0]    event2,
	input  wire [`EVT_W-1:0]    event3,
	input  wire [`EVT_W-1:0]    event4,
	input  wire [`ADJ_W-1:0]    cycle_adj_a,
	input  wire [`ADJ_W-1:0]    cycle_adj_b,
	input  wire [`ADJ_W-1:0]    adapt_offset,
	input  wire                 adapt_half_sel,
	input  wire [`CNT_W-1:0]    dead_time_ab,
	input  wire [`CNT_W-1:0]    dead_time_ba,
	// Fixed-point settings
	input  wire [`CNT_W-1:0]    sample_point1,
	input  wire [`CNT_W-1:0]    sample_point2,
	input  wire [`CNT_W-1:0]    blank_a_begin,
	input  wire [`CNT_W-1:0]    blank_a_end,
	input  wire [`CNT_W-1:0]    blank_b_begin,
	input  wire [`CNT_W-1:0]    blank_b_end,
	input  wire [`CNT_W-1:0]    phase_value,
	input  wire                 phase_from_duty,
	// Mode control
	input  wire [`MODE_W-1:0]   mode_select,
	input  wire                 auto_switch_en,
	input  wire [`CNT_W-1:0]    auto_thresh_mid,
	input  wire [`CNT_W-1:0]    auto_thresh_high,
	input  wire [`MODE_W-1:0]   auto_mode_mid,
	input  wire [`MODE_W-1:0]   auto_mode_high,
	// Filter outputs
	input  wire [`CNT_W-1:0]    filter_duty,
	input  wire [`CNT_W-1:0]    filter_period,
	// Sync rectifier control
	input  wire                 nominal_reached,
	input  wire                 sr_ramp_enable,
	input  wire [7:0]           sr_ramp_step,
	input  wire [7:0]           sr_ramp_periods,
	input  wire [`VOLT_W-1:0]   vin_value,
	input  wire [`VOLT_W-1:0]   vout_value,
	// Gate drive outputs
	output reg                  pwm_output_a,
	output reg                  pwm_output_b,
	output reg  [3:0]           hr_frac_b_q,
	// Triggers and windows
	output reg                  error_converter_start,
	output reg                  sample2_pulse,
	output reg                  adapt_trig_pulse,
	output reg                  phase_trig_pulse,
	output reg                  period_start_pulse,
	output reg                  blank_a,
	output reg                  blank_b,
	// Status
	output reg  [`CNT_W-1:0]    count_q,
	output reg  [`MODE_W-1:0]   mode_q,
	output wire [`CNT_W-1:0]    sr_on_time,
	output wire                 sr_ramp_done
);

	////////////////////////////////////////////////////////////////////////
	// Saturate a signed target into 0..lim
	function [`CNT_W-1:0] clampv;
		input signed [16:0]     v;
		input [`CNT_W-1:0]      lim;
		begin
			if (v < 0)
				clampv = `RST_CNT;
			else if (v > $signed({3'b000, lim}))
				clampv = lim;
			else
				clampv = v[13:0];
		end
	endfunction

	// Fold a target past the limit into the next period
	function [`CNT_W-1:0] wrapv;
		input signed [16:0]     v;
		input [`CNT_W-1:0]      lim;
		reg signed [16:0]       w;
		begin
			w = v - $signed({3'b000, lim}) - 17'sd1;
			if (v > $signed({3'b000, lim}))
				wrapv = clampv(w, lim);
			else
				wrapv = clampv(v, lim);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Latched per-period state
	reg  [`CNT_W-1:0]           lim_q;
	reg  [`CNT_W-1:0]           ar_q;
	reg  [`CNT_W-1:0]           af_q;
	reg  [`CNT_W-1:0]           br_q;
	reg  [`CNT_W-1:0]           bf_q;
	reg  [`CNT_W-1:0]           ad_q;
	reg  [`CNT_W-1:0]           ph_q;
	reg                         a_en_q;
	reg                         ad_en_q;

	// Next-period computation
	reg  [`MODE_W-1:0]          mode_n;
	reg  [`CNT_W-1:0]           lim_n;
	reg  signed [16:0]          ar;
	reg  signed [16:0]          af;
	reg  signed [16:0]          br;
	reg  signed [16:0]          bf;
	reg  signed [16:0]          ad;
	reg                         a_en;
	reg                         ad_en;
	reg                         b_wrap;
	reg  [`CNT_W-1:0]           ar_t;
	reg  [`CNT_W-1:0]           af_t;
	reg  [`CNT_W-1:0]           br_t;
	reg  [`CNT_W-1:0]           bf_t;
	reg  [`CNT_W-1:0]           ad_t;
	reg  [`CNT_W-1:0]           ph_t;

	wire                        wrap = (count_q >= lim_q);

	////////////////////////////////////////////////////////////////////////
	// Operand extension; events 2-4 compare on their whole-cycle field
	wire signed [16:0] e1_s  = {3'b000, event1};
	wire signed [16:0] e2_s  = {3'b000, event2[`EVT_CNT_MSB:`EVT_CNT_LSB]};
	wire signed [16:0] e3_s  = {3'b000, event3[`EVT_CNT_MSB:`EVT_CNT_LSB]};
	wire signed [16:0] e4_s  = {3'b000, event4[`EVT_CNT_MSB:`EVT_CNT_LSB]};
	wire signed [16:0] du_s  = {3'b000, filter_duty};
	wire signed [16:0] hd_s  = {4'b0000, filter_duty[13:1]};
	wire signed [16:0] caa_s = {cycle_adj_a[15], cycle_adj_a};
	wire signed [16:0] cab_s = {cycle_adj_b[15], cycle_adj_b};
	wire signed [16:0] ofs_s = {adapt_offset[15], adapt_offset};
	wire signed [16:0] hp_s  = {4'b0000, lim_n[13:1]};
	wire signed [16:0] dab_s = {3'b000, dead_time_ab};
	wire        [14:0] dsum  = {1'b0, dead_time_ab} + {1'b0, dead_time_ba};
	wire signed [16:0] ton_s = du_s - {3'b000, dsum[14:1]};

	////////////////////////////////////////////////////////////////////////
	// Mode choice: auto switching picks by filter duty level
	always @* begin
		mode_n = mode_select;
		if (auto_switch_en) begin
			if (filter_duty > auto_thresh_high)
				mode_n = auto_mode_high;
			else if (filter_duty > auto_thresh_mid)
				mode_n = auto_mode_mid;
		end
		// Resonant period tracks the filter, which runs it at twice duty
		lim_n = (mode_n == `MODE_RESONANT) ? filter_period : period_limit;
	end

	////////////////////////////////////////////////////////////////////////
	// Edge equations per mode
	always @* begin
		a_en   = 1'b1;
		ad_en  = 1'b1;
		b_wrap = 1'b0;
		ar     = e1_s;
		af     = e1_s + du_s + caa_s;
		br     = af + (e3_s - e2_s);
		bf     = e4_s;
		ad     = adapt_half_sel ? (e1_s + hd_s + ofs_s) : (e1_s + du_s + ofs_s);
		case (mode_n)
			`MODE_NORMAL: begin
				// Cycle adjust B takes no part here
				af = e1_s + du_s + caa_s;
				br = af + (e3_s - e2_s);
				bf = e4_s;
			end
			`MODE_MULTI: begin
				br     = e3_s;
				bf     = e3_s + du_s + cab_s;
				b_wrap = 1'b1;
			end
			`MODE_RESONANT: begin
				ad_en = 1'b0;
				ar    = e1_s;
				af    = e1_s + ton_s;
				br    = af + dab_s;
				bf    = br + ton_s;
				b_wrap = 1'b1;
			end
			`MODE_TRIANG: begin
				a_en  = 1'b0;
				ad_en = 1'b0;
				br    = hp_s - hd_s + caa_s;
				bf    = hp_s + hd_s + cab_s;
			end
			`MODE_LEADING: begin
				af = e1_s;
				ar = e1_s - du_s + caa_s;
				br = e4_s;
				bf = e1_s - du_s + caa_s - (e2_s - e3_s);
				ad = adapt_half_sel ? (e1_s - hd_s + ofs_s) : (e1_s - du_s + ofs_s);
			end
			default: begin
				a_en = 1'b1;
			end
		endcase
		ar_t = clampv(ar, lim_n);
		af_t = clampv(af, lim_n);
		br_t = clampv(br, lim_n);
		bf_t = b_wrap ? wrapv(bf, lim_n) : clampv(bf, lim_n);
		ad_t = clampv(ad, lim_n);
		// Phase source is either a fixed value or the live duty
		ph_t = phase_from_duty ? filter_duty : phase_value;
		if (ph_t > lim_n)
			ph_t = lim_n;
	end

	////////////////////////////////////////////////////////////////////////
	// Period counter and boundary latch; avoids mid-period target tearing
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			count_q <= `RST_CNT;
			lim_q   <= `RST_CNT;
			mode_q  <= `RST_MODE;
			ar_q    <= `RST_CNT;
			af_q    <= `RST_CNT;
			br_q    <= `RST_CNT;
			bf_q    <= `RST_CNT;
			ad_q    <= `RST_CNT;
			ph_q    <= `RST_CNT;
			a_en_q  <= 1'b0;
			ad_en_q <= 1'b0;
			hr_frac_b_q <= 4'h0;
		end else if (wrap) begin
			count_q <= `RST_CNT;
			lim_q   <= lim_n;
			mode_q  <= mode_n;
			ar_q    <= ar_t;
			af_q    <= af_t;
			br_q    <= br_t;
			bf_q    <= bf_t;
			ad_q    <= ad_t;
			ph_q    <= ph_t;
			a_en_q  <= a_en;
			ad_en_q <= ad_en;
			// Fine fraction of event4 (B fall in normal mode, B rise in leading mode), for the delay line
			hr_frac_b_q <= event4[3:0];
		end else begin
			count_q <= count_q + 14'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gate outputs: set/clear on compare, one clock after the match
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			pwm_output_a <= 1'b0;
			pwm_output_b <= 1'b0;
		end else begin
			// A never carries over the boundary
			if (!a_en_q || wrap)
				pwm_output_a <= 1'b0;
			else if (count_q == ar_q && ar_q != af_q)
				pwm_output_a <= 1'b1;
			else if (count_q == af_q)
				pwm_output_a <= 1'b0;
			// Rise beats fall on a tie, so B can reach full duty
			if (count_q == br_q)
				pwm_output_b <= 1'b1;
			else if (count_q == bf_q)
				pwm_output_b <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample triggers and blanking windows compare live inputs; adapt and phase triggers use latched targets
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			error_converter_start <= 1'b0;
			sample2_pulse         <= 1'b0;
			adapt_trig_pulse      <= 1'b0;
			phase_trig_pulse      <= 1'b0;
			period_start_pulse    <= 1'b0;
			blank_a               <= 1'b0;
			blank_b               <= 1'b0;
		end else begin
			error_converter_start <= (count_q == sample_point1);
			sample2_pulse         <= (count_q == sample_point2);
			adapt_trig_pulse      <= ad_en_q && (count_q == ad_q);
			phase_trig_pulse      <= (count_q == ph_q);
			period_start_pulse    <= wrap;
			if (count_q == blank_a_begin)
				blank_a <= 1'b1;
			else if (count_q == blank_a_end)
				blank_a <= 1'b0;
			if (count_q == blank_b_begin)
				blank_b <= 1'b1;
			else if (count_q == blank_b_end)
				blank_b <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sync rectifier on-time
	sync_rect_unit u_sync_rect (
		.clock           (clock),
		.reset           (reset),
		.period_start    (wrap),
		.nominal_reached (nominal_reached),
		.ramp_enable     (sr_ramp_enable),
		.ramp_step       (sr_ramp_step),
		.ramp_periods    (sr_ramp_periods),
		.vin             (vin_value),
		.vout            (vout_value),
		.duty            (filter_duty),
		.on_time_q       (sr_on_time),
		.ramp_done_q     (sr_ramp_done)
	);

endmodule // multi_mode_pwm_edge_engine

// *** tb/filter_model.sv ***
/* Filter model: duty as asked, period twice the duty.
   Assumes the engine clock and reset. */
`timescale 1ns/1ps
module filter_model (
	// Clock and reset
	input  wire        clock,
	input  wire        reset,
	// Duty asked for, filter outputs
	input  wire [13:0] duty_req,
	output reg  [13:0] filter_duty,
	output reg  [13:0] filter_period
);
	// Registered, so a new duty lands one cycle late
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			filter_duty <= 14'h0000;
			filter_period <= 14'h0000;
		end else begin
			filter_duty <= duty_req;
			filter_period <= duty_req << 1;
		end
	end
endmodule // filter_model

// *** tb/multi_mode_pwm_edge_engine_assertions.sv ***
/* Checker: counter, compare triggers, blanking, triangular quiet, rectifier hold-off.
   Assumes a bind onto the engine top. */
`timescale 1ns/1ps
`include "pwm_edge_map.vh"
module pwm_edge_checker (
	// Clock, reset, settings
	input wire               clock,
	input wire               reset,
	input wire [`CNT_W-1:0]  sample_point1,
	input wire [`CNT_W-1:0]  sample_point2,
	input wire [`CNT_W-1:0]  blank_a_begin,
	input wire [`CNT_W-1:0]  blank_a_end,
	input wire               nominal_reached,
	// Outputs
	input wire [`CNT_W-1:0]  count_q,
	input wire [`MODE_W-1:0] mode_q,
	input wire               pwm_output_a,
	input wire               error_converter_start,
	input wire               sample2_pulse,
	input wire               adapt_trig_pulse,
	input wire               period_start_pulse,
	input wire               blank_a,
	input wire [`CNT_W-1:0]  sr_on_time
);
	reg [7:0] held_q;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	// Cycles below nominal; saturates rather than wrap
	always @(posedge clock or posedge reset) begin
		if (reset)
			held_q <= 8'h00;
		else if (nominal_reached)
			held_q <= 8'h00;
		else if (held_q != 8'hFF)
			held_q <= held_q + 8'h01;
	end
	////////////////////////////////////////
	// Counter, triggers and windows
	property p_step; count_q == 14'h0000 || count_q == $past(count_q) + 14'h0001; endproperty
	a_step: assert property (p_step) else $error("count step");
	property p_wrap; period_start_pulse |-> count_q == 14'h0000; endproperty
	a_wrap: assert property (p_wrap) else $error("wrap");
	property p_conv; count_q == sample_point1 |=> error_converter_start; endproperty
	a_conv: assert property (p_conv) else $error("conv start");
	property p_conv_why; error_converter_start |-> $past(count_q) == $past(sample_point1); endproperty
	a_conv_why: assert property (p_conv_why) else $error("conv cause");
	property p_s2_why; sample2_pulse |-> $past(count_q) == $past(sample_point2); endproperty
	a_s2_why: assert property (p_s2_why) else $error("sample2 cause");
	property p_bl_set; count_q == blank_a_begin |=> blank_a; endproperty
	a_bl_set: assert property (p_bl_set) else $error("blank set");
	property p_bl_clr; count_q == blank_a_end && count_q != blank_a_begin |=> !blank_a; endproperty
	a_bl_clr: assert property (p_bl_clr) else $error("blank clear");
	property p_tri_a; mode_q == `MODE_TRIANG |-> !pwm_output_a; endproperty
	a_tri_a: assert property (p_tri_a) else $error("triangular a");
	property p_tri_ad; mode_q == `MODE_TRIANG && $past(mode_q) == `MODE_TRIANG |-> !adapt_trig_pulse; endproperty
	a_tri_ad: assert property (p_tri_ad) else $error("triangular adapt");
	property p_sr_off; held_q == 8'hFF |-> sr_on_time == 14'h0000; endproperty
	a_sr_off: assert property (p_sr_off) else $error("rectifier on early");
endmodule // pwm_edge_checker
bind multi_mode_pwm_edge_engine pwm_edge_checker chk_u (.*);

// *** tb/multi_mode_pwm_edge_engine_tb_top.sv ***
/* Bench: random settings in every mode against its own edge model.
   Assumes filter_model and the bound checker. */
`timescale 1ns/1ps
module multi_mode_pwm_edge_engine_tb_top;
	reg clock, reset, adapt_half_sel, phase_from_duty, auto_switch_en, nominal_reached;
	reg sr_ramp_enable;
	reg [13:0] period_limit, event1, dead_time_ab, dead_time_ba, sample_point1, sample_point2;
	reg [13:0] blank_a_begin, blank_a_end, blank_b_begin, blank_b_end, phase_value, duty_req;
	reg [13:0] auto_thresh_mid, auto_thresh_high;
	reg [17:0] event2, event3, event4;
	reg [15:0] cycle_adj_a, cycle_adj_b, adapt_offset;
	reg [2:0]  mode_select, auto_mode_mid, auto_mode_high;
	reg [7:0]  sr_ramp_step, sr_ramp_periods;
	reg [11:0] vin_value, vout_value;
	wire pwm_output_a, pwm_output_b, error_converter_start, sample2_pulse, adapt_trig_pulse;
	wire phase_trig_pulse, period_start_pulse, blank_a, blank_b, sr_ramp_done;
	wire [3:0]  hr_frac_b_q;
	wire [13:0] count_q, sr_on_time, filter_duty, filter_period;
	wire [2:0]  mode_q;
	integer err_count, samples_checked, seed, cnt, lim, ar, af, br, bf, ad, ph, md, nb, fr, i;
	reg a_e, b_e, ad_e, ph_e, bb_e, cs_e, s2_e, ps_e;
	multi_mode_pwm_edge_engine dut_u (.*);
	filter_model filt_u (.*);
	////////////////////////////////////////
	// Clamp into the period; B may wrap past it
	function integer cl(input integer v);
		cl = v < 0 ? 0 : (v > lim ? lim : v);
	endfunction
	function integer wr(input integer v);
		wr = cl(v > lim ? v - lim - 1 : v);
	endfunction
	function integer r(input integer n);
		r = {$random(seed)} % n;
	endfunction
	task chk(input [63:0] nm, input [13:0] ex, input [13:0] got);
		begin
			samples_checked = samples_checked + 1;
			if (got !== ex) begin
				err_count = err_count + 1;
				$display("MISMATCH %0s expected %0h seen %0h", nm, ex, got);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, err_count);
			if (err_count == 0 && samples_checked > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	////////////////////////////////////////
	// Next-period targets, taken only at the wrap
	task latch;
		integer d, e1, e2, e3, ja, jb, of, ton;
		begin
			d = filter_duty;
			e1 = event1;
			e2 = event2[17:4];
			e3 = event3[17:4];
			ja = $signed(cycle_adj_a);
			jb = $signed(cycle_adj_b);
			of = $signed(adapt_offset);
			md = mode_select;
			if (auto_switch_en && d > auto_thresh_high)
				md = auto_mode_high;
			else if (auto_switch_en && d > auto_thresh_mid)
				md = auto_mode_mid;
			lim = md == 2 ? filter_period : period_limit;
			fr = event4[3:0];
			ton = d - (dead_time_ab + dead_time_ba) / 2;
			ar = cl(e1);
			af = cl(e1 + d + ja);
			br = cl(e1 + d + ja + e3 - e2);
			bf = cl(event4[17:4]);
			ad = cl(e1 + (adapt_half_sel ? d / 2 : d) + of);
			ph = cl(phase_from_duty ? d : phase_value);
			if (md == 1) begin
				br = cl(e3);
				bf = wr(e3 + d + jb);
			end else if (md == 2) begin
				af = cl(e1 + ton);
				br = cl(e1 + ton + dead_time_ab);
				bf = wr(e1 + ton + dead_time_ab + ton);
			end else if (md == 3) begin
				br = cl(lim / 2 - d / 2 + ja);
				bf = cl(lim / 2 + d / 2 + jb);
			end else if (md == 4) begin
				af = cl(e1);
				ar = cl(e1 - d + ja);
				br = cl(event4[17:4]);
				bf = cl(e1 - d + ja - (e2 - e3));
				ad = cl(e1 - (adapt_half_sel ? d / 2 : d) + of);
			end
		end
	endtask
	// Reference outputs; old targets still rule the wrap cycle
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			cnt = 0;
			lim = 0;
			nb = 0;
			bb_e = 0;
		end else begin
			if (cnt == br)
				b_e = 1;
			else if (cnt == bf)
				b_e = 0;
			if (cnt >= lim || md == 3 || cnt == af)
				a_e = 0;
			else if (cnt == ar && ar != af)
				a_e = 1;
			ad_e = cnt == ad && md != 2 && md != 3;
			ph_e = cnt == ph;
			// Live compare points, read before the boundary moves lim
			cs_e = cnt == sample_point1;
			s2_e = cnt == sample_point2;
			ps_e = cnt >= lim;
			if (cnt == blank_b_begin)
				bb_e = 1;
			else if (cnt == blank_b_end)
				bb_e = 0;
			if (cnt >= lim) begin
				latch;
				cnt = 0;
				nb = nb + 1;
			end else
				cnt = cnt + 1;
		end
	end
	// Compare once the model has seen a full period
	always @(negedge clock) begin
		if (!reset && nb > 1) begin
			chk("count", cnt, count_q);
			chk("mode", md, mode_q);
			chk("out_a", a_e, pwm_output_a);
			chk("out_b", b_e, pwm_output_b);
			chk("adapt", ad_e, adapt_trig_pulse);
			chk("phase", ph_e, phase_trig_pulse);
			chk("frac", fr, hr_frac_b_q);
			chk("conv", cs_e, error_converter_start);
			chk("sample2", s2_e, sample2_pulse);
			chk("pstart", ps_e, period_start_pulse);
			chk("blank_b", bb_e, blank_b);
		end
	end
	////////////////////////////////////////
	// Random settings; resonant ranges keep A and B rise inside the period, B fall always wraps
	task cfg(input integer m, input integer au);
		begin
			mode_select = m;
			auto_switch_en = au;
			period_limit = 120 + r(80);
			event1 = (m == 2 ? 10 : 30) + r(20);
			duty_req = m == 2 ? 40 + r(20) : r(60);
			event2 = ((60 + r(10)) << 4) + r(16);
			event3 = event2 + (r(20) << 4);
			event4 = ((100 + r(19)) << 4) + r(16);
			cycle_adj_a = $random(seed) % 8;
			cycle_adj_b = $random(seed) % 8;
			adapt_offset = $random(seed) % 8;
			{adapt_half_sel, phase_from_duty} = r(4);
			phase_value = r(220);
			dead_time_ab = 3 + r(4);
			dead_time_ba = 3 + r(4);
			sample_point1 = r(120);
			sample_point2 = r(120);
			blank_a_begin = r(120);
			blank_a_end = r(120);
			blank_b_begin = r(120);
			blank_b_end = r(120);
		end
	endtask
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	// Hang guard, well past the planned run
	initial begin
		#400000;
		err_count = err_count + 1;
		finish_test;
	end
	// Main sequence: all modes, auto switching, rectifier ramp
	initial begin
		seed = 96;
		err_count = 0;
		samples_checked = 0;
		reset = 1;
		{adapt_half_sel, phase_from_duty, auto_switch_en, nominal_reached, sr_ramp_enable} = 0;
		{period_limit, event1, dead_time_ab, dead_time_ba, sample_point1, sample_point2} = 0;
		{blank_a_begin, blank_a_end, blank_b_begin, blank_b_end, phase_value, duty_req} = 0;
		{event2, event3, event4, cycle_adj_a, cycle_adj_b, adapt_offset, mode_select} = 0;
		{sr_ramp_periods, blank_b_begin, blank_b_end} = 0;
		auto_thresh_mid = 14'h0014;
		auto_thresh_high = 14'h0028;
		auto_mode_mid = 3'h1;
		auto_mode_high = 3'h4;
		vin_value = 12'h9C4;
		vout_value = 12'h3E8;
		sr_ramp_enable = 1'b1;
		sr_ramp_step = 8'h07;
		repeat (10) @(negedge clock);
		reset = 0;
		for (i = 0; i < 25; i = i + 1) begin
			cfg(i % 5, i > 19);
			repeat (630) @(negedge clock);
		end
		duty_req = 14'h0028;
		// Step only every second boundary, so the divider is exercised
		sr_ramp_periods = 8'h01;
		nominal_reached = 1'b1;
		repeat (6000) @(negedge clock);
		chk("sr_time", 60, sr_on_time);
		chk("sr_done", 1, sr_ramp_done);
		finish_test;
	end
endmodule // multi_mode_pwm_edge_engine_tb_top
